// *** hw/flash_self_program_defs.vh ***
// Constants for the flash self-programming control block.
`ifndef FLASH_SELF_PROGRAM_DEFS_VH
`define FLASH_SELF_PROGRAM_DEFS_VH
// ****************************************************************
// Register offsets (byte addresses on APB)
// ****************************************************************
`define SPC_OFF_CTRL 12'h000
`define SPC_OFF_PTR_LO 12'h004
`define SPC_OFF_PTR_HI 12'h008
`define SPC_OFF_MISC 12'h00C
// ****************************************************************
// Control register fields
// ****************************************************************
`define SPC_BIT_IE 7
`define SPC_BIT_BUSY 6
`define SPC_BIT_SIG 5
`define SPC_BIT_REEN 4
`define SPC_BIT_BLB 3
`define SPC_BIT_WR 2
`define SPC_BIT_ERS 1
`define SPC_BIT_EN 0
`define SPC_CTRL_RESET 8'h00
// Permitted low six-bit command patterns.
`define SPC_CMD_SIG 6'h21
`define SPC_CMD_REEN 6'h11
`define SPC_CMD_BLB 6'h09
`define SPC_CMD_WR 6'h05
`define SPC_CMD_ERS 6'h03
`define SPC_CMD_FILL 6'h01
// ****************************************************************
// Timing
// ****************************************************************
`define SPC_STORE_WIN 3'h4
`define SPC_LOAD_WIN 3'h3
`define SPC_OP_CYCLES 16'h0100
// ****************************************************************
// Pointer layout
// ****************************************************************
`define SPC_WORD_BITS 6
`define SPC_WORDS 64
`define SPC_NON_CONCURRENT_AREA_PAGE 9'h100
`define SPC_APB_OK 1'b0
`define SPC_APB_ERR 1'b1
`endif

// *** hw/flash_self_program_control.v ***
// Flash self-programming control: command window, page buffer, erase/write sequencing.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Function
// R01 - Signature command plus load instruction within three cycles returns a signature byte.
// R02 - Store instruction after signature command does nothing.
// R03 - Erase or write to concurrent area sets busy and blocks its reads.
// R04 - Re-enable command plus store within four cycles clears busy; refused while busy.
// R05 - Re-enable during buffer load aborts the load and discards buffer data.
// R06 - Boot lock command plus store sets lock bits from R0 only.
// R07 - Boot lock command plus load returns lock or fuse bits by pointer bit 0.
// R08 - Page write command plus store writes buffer to pointer page.
// R09 - Page erase command plus store erases pointer page.
// R10 - CPU is halted during erase or write of the non-concurrent area.
// R11 - Non-concurrent area stays readable during concurrent-area programming.
// R12 - Plain enable plus store puts R1:R0 in buffer, pointer bit 0 ignored.
// R13 - Enable clears on store or four-cycle timeout; held during erase or write.
// R14 - Control writes with an unpermitted low pattern have no effect (the code still takes bit 7, interrupt enable, from them).
// R15 - Target address is latched when an operation starts.
// R16 - Load instruction addresses bytes using all pointer bits.
// R17 - Buffer clears after page write, re-enable write and reset.
// R18 - Software writes each buffer word at most once between erasures.
// R19 - Word field selects buffer word; page field selects erase or write page.
// R20 - With interrupt enabled, request stands while enable is clear.
// R21 - Software erases before writing and uses the same page for both.
// R22 - Software loads pointer, writes command, then stores within four cycles.
// R23 - Starting a buffer load clears concurrent busy.
// R24 - Interrupt enable is bit 7 gated by global flag; busy is bit 6, read-only.
// R25 - Window counts from the control write and clears all command bits on expiry.
`include "flash_self_program_defs.vh"

module flash_self_program_control (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // CPU instruction strobes and operands
    input wire store_instr_i,
    input wire load_instr_i,
    input wire [7:0] r0_i,
    input wire [7:0] r1_i,
    input wire global_irq_en_i,
    // Special load answer
    output reg load_special_o,
    output reg [7:0] load_data_o,
    // Flash array side
    input wire [7:0] sig_byte_i,
    input wire [7:0] fuse_byte_i,
    output reg [15:0] sig_addr_o,
    output reg [8:0] flash_page_o,
    output reg flash_erase_o,
    output reg flash_write_o,
    output reg [15:0] flash_wdata_o,
    output reg [5:0] flash_widx_o,
    // Status to the core
    output reg cpu_halt_o,
    output reg concurrent_read_block_o,
    output reg irq_o,
    output reg [7:0] lock_bits_o
);

// ****************************************************************
// State
// ****************************************************************
localparam ST_IDLE = 2'b00;
localparam ST_ERASE = 2'b01;
localparam ST_WRITE = 2'b10;

reg [7:0] ctrl_q;
reg [7:0] ptr_lo_q;
reg [7:0] ptr_hi_q;
reg [2:0] win_q;
reg [1:0] state_q;
reg [15:0] op_cnt_q;
reg [8:0] page_q;
reg [5:0] wr_idx_q;
reg [15:0] buf_q [0:`SPC_WORDS-1];
reg [`SPC_WORDS-1:0] buf_valid_q;


// ****************************************************************
// Pointer fields
// ****************************************************************
wire [15:0] ptr = {ptr_hi_q, ptr_lo_q};
wire [5:0] cmd = ctrl_q[5:0];
wire busy_op = (state_q != ST_IDLE);
wire [8:0] ptr_page = ptr[15:7];
wire [5:0] ptr_word = ptr[6:1];

wire bus_wr = psel_i & penable_i & pwrite_i;
wire ctrl_wr = bus_wr & (paddr_i == `SPC_OFF_CTRL);
wire [5:0] wcmd = pwdata_i[5:0];

// ****************************************************************
// Command decode
// ****************************************************************
// Only six patterns are accepted, and never while an erase or write runs.
reg wcmd_known;
always @* begin
    wcmd_known = 1'b0;
    case (wcmd)
        `SPC_CMD_SIG: wcmd_known = 1'b1;
        `SPC_CMD_REEN: wcmd_known = 1'b1;
        `SPC_CMD_BLB: wcmd_known = 1'b1;
        `SPC_CMD_WR: wcmd_known = 1'b1;
        `SPC_CMD_ERS: wcmd_known = 1'b1;
        `SPC_CMD_FILL: wcmd_known = 1'b1;
        default: wcmd_known = 1'b0; // R14
    endcase
end
wire wcmd_ok = ~busy_op & wcmd_known; // R14

// Answer byte for a special load; lock bits sit at the odd pointer, the fuse byte at the even one.
reg [7:0] load_pick;
always @* begin
    load_pick = 8'h00;
    case (cmd)
        `SPC_CMD_SIG: load_pick = sig_byte_i; // R01
        `SPC_CMD_BLB: begin
            if (ptr[0]) begin
                load_pick = lock_bits_o; // R07
            end else begin
                load_pick = fuse_byte_i; // R07
            end
        end
        default: load_pick = 8'h00;
    endcase
end
wire armed = ctrl_q[`SPC_BIT_EN] & ~busy_op;
wire store_go = armed & store_instr_i & (win_q < `SPC_STORE_WIN);
wire load_go = armed & load_instr_i & (win_q < `SPC_LOAD_WIN);

// ****************************************************************
// Command window and sequencer
// ****************************************************************
// A control write owns its cycle, so a running operation pauses its count for it.
// This stretches the operation by one cycle per write, which software cannot see.
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        ctrl_q <= `SPC_CTRL_RESET;
        win_q <= 3'h0;
        state_q <= ST_IDLE;
        op_cnt_q <= 16'h0000;
        page_q <= 9'h000;
        lock_bits_o <= 8'hFF;
        buf_valid_q <= {`SPC_WORDS{1'b0}}; // R17
        flash_erase_o <= 1'b0;
        flash_write_o <= 1'b0;
        load_special_o <= 1'b0;
        load_data_o <= 8'h00;
        sig_addr_o <= 16'h0000;
        wr_idx_q <= 6'h00;
    end else begin
        flash_erase_o <= 1'b0;
        flash_write_o <= 1'b0;
        load_special_o <= 1'b0;
        // The row address follows the pointer every cycle so the row byte has settled when a load arrives.
        sig_addr_o <= ptr; // R16
        if (ctrl_wr) begin
            ctrl_q[`SPC_BIT_IE] <= pwdata_i[`SPC_BIT_IE]; // R24
            if (wcmd_ok) begin
                ctrl_q[5:0] <= wcmd;
                win_q <= 3'h0; // R25
                if (wcmd == `SPC_CMD_REEN) begin
                    buf_valid_q <= {`SPC_WORDS{1'b0}}; // R05 R17
                end
            end
        end else if (busy_op) begin
            if (op_cnt_q == 16'h0000) begin
                state_q <= ST_IDLE;
                ctrl_q[5:0] <= 6'h00; // R13
                if (state_q == ST_WRITE) begin
                    buf_valid_q <= {`SPC_WORDS{1'b0}}; // R17
                end
            end else begin
                op_cnt_q <= op_cnt_q - 16'h0001;
            end
        end else if (load_go && (cmd == `SPC_CMD_SIG || cmd == `SPC_CMD_BLB)) begin
            load_special_o <= 1'b1;
            load_data_o <= load_pick; // R01 R07
            ctrl_q[5:0] <= 6'h00;
        end else if (store_go) begin
            ctrl_q[5:0] <= 6'h00; // R13
            case (cmd)
                `SPC_CMD_ERS: begin
                    page_q <= ptr_page; // R09 R15 R19
                    state_q <= ST_ERASE;
                    op_cnt_q <= `SPC_OP_CYCLES;
                    flash_erase_o <= 1'b1;
                    ctrl_q[5:0] <= cmd; // R13
                end
                `SPC_CMD_WR: begin
                    page_q <= ptr_page; // R08 R15 R19
                    state_q <= ST_WRITE;
                    op_cnt_q <= `SPC_OP_CYCLES;
                    flash_write_o <= 1'b1;
                    ctrl_q[5:0] <= cmd; // R13
                end
                `SPC_CMD_FILL: begin
                    buf_valid_q[ptr_word] <= 1'b1; // R12 R19
                    wr_idx_q <= ptr_word;
                end
                `SPC_CMD_BLB: begin
                    lock_bits_o <= lock_bits_o & r0_i; // R06
                end
                default: begin
                    // Signature and re-enable stores change nothing here.  // R02
                end
            endcase
        end else if (ctrl_q[`SPC_BIT_EN]) begin
            if (win_q == `SPC_STORE_WIN - 3'h1) begin
                ctrl_q[5:0] <= 6'h00; // R13 R25
            end else begin
                win_q <= win_q + 3'h1;
            end
        end
    end
end

// Buffer data kept in its own array; a valid bit marks filled words, and unfilled words read as 16'hFFFF.
always @(posedge clk_sys_i) begin
    if (store_go && cmd == `SPC_CMD_FILL) begin
        buf_q[ptr_word] <= {r1_i, r0_i};
    end
end

// ****************************************************************
// Concurrent-area busy and outputs
// ****************************************************************
reg busy_q;
reg busy_d;
// Set by a start into the shared area; cleared by a re-enable store or by a buffer fill.
always @* begin
    busy_d = busy_q;
    if (store_go) begin
        case (cmd)
            `SPC_CMD_ERS: begin
                if (ptr_page < `SPC_NON_CONCURRENT_AREA_PAGE) begin
                    busy_d = 1'b1; // R03
                end
            end
            `SPC_CMD_WR: begin
                if (ptr_page < `SPC_NON_CONCURRENT_AREA_PAGE) begin
                    busy_d = 1'b1; // R03
                end
            end
            `SPC_CMD_REEN: busy_d = 1'b0; // R04
            `SPC_CMD_FILL: busy_d = 1'b0; // R23
            default: busy_d = busy_q;
        endcase
    end
end

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        busy_q <= 1'b0;
    end else begin
        busy_q <= busy_d;
    end
end

wire page_non_concurrent_area = (page_q >= `SPC_NON_CONCURRENT_AREA_PAGE);
// Halt drops on the last count so the core resumes as the sequencer goes idle.
wire halt_d = busy_op & page_non_concurrent_area & (op_cnt_q != 16'h0000); // R10
// The request is a level: it stands for as long as the enable bit stays clear.
wire irq_d = ctrl_q[`SPC_BIT_IE] & global_irq_en_i & ~ctrl_q[`SPC_BIT_EN]; // R20 R24

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        cpu_halt_o <= 1'b0;
        concurrent_read_block_o <= 1'b0;
        irq_o <= 1'b0;
        flash_page_o <= 9'h000;
        flash_wdata_o <= 16'h0000;
        flash_widx_o <= 6'h00;
    end else begin
        cpu_halt_o <= halt_d; // R10
        concurrent_read_block_o <= busy_q; // R03 R11
        irq_o <= irq_d; // R20 R24
        flash_page_o <= page_q;
        flash_widx_o <= wr_idx_q;
        flash_wdata_o <= buf_valid_q[wr_idx_q] ? buf_q[wr_idx_q] : 16'hFFFF;
    end
end

// ****************************************************************
// APB slave
// ****************************************************************
// Read data is chosen in the setup cycle and registered, so it stands in the access cycle.
reg [31:0] rd_d;
reg rd_err_d;
always @* begin
    rd_d = 32'h00000000;
    rd_err_d = `SPC_APB_OK;
    case (paddr_i)
        `SPC_OFF_CTRL: rd_d = {24'h000000, ctrl_q[7], busy_q, ctrl_q[5:0]}; // R24
        `SPC_OFF_PTR_LO: rd_d = {24'h000000, ptr_lo_q};
        `SPC_OFF_PTR_HI: rd_d = {24'h000000, ptr_hi_q};
        `SPC_OFF_MISC: rd_d = {24'h000000, lock_bits_o};
        default: begin
            rd_d = 32'h00000000;
            rd_err_d = `SPC_APB_ERR;
        end
    endcase
end

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        ptr_lo_q <= 8'h00;
        ptr_hi_q <= 8'h00;
        prdata_o <= 32'h00000000;
        pready_o <= 1'b0;
        pslverr_o <= 1'b0;
    end else begin
        pready_o <= psel_i & ~penable_i;
        pslverr_o <= `SPC_APB_OK;
        if (bus_wr && paddr_i == `SPC_OFF_PTR_LO) begin
            ptr_lo_q <= pwdata_i[7:0];
        end
        if (bus_wr && paddr_i == `SPC_OFF_PTR_HI) begin
            ptr_hi_q <= pwdata_i[7:0];
        end
        if (psel_i && !penable_i) begin
            prdata_o <= rd_d;
            pslverr_o <= rd_err_d;
        end
    end
end

endmodule

// *** tb/flash_self_program_checker.sv ***
// Port-level assertions for the flash self-programming control block.
`timescale 1ns/1ps
module flash_self_program_checker (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    // CPU side
    input wire store_instr_i,
    input wire load_instr_i,
    input wire global_irq_en_i,
    input wire load_special_o,
    input wire cpu_halt_o,
    input wire concurrent_read_block_o,
    input wire irq_o,
    // Flash side
    input wire [8:0] flash_page_o,
    input wire flash_erase_o,
    input wire flash_write_o,
    input wire [7:0] lock_bits_o
);
    wire start_w = flash_erase_o || flash_write_o;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_ld; load_special_o |-> $past(load_instr_i); endproperty
    a_ld: assert property (p_ld) else $error("load answer without load");
    property p_ers; flash_erase_o |-> $past(store_instr_i); endproperty
    a_ers: assert property (p_ers) else $error("erase without store");
    property p_wr; flash_write_o |-> $past(store_instr_i); endproperty
    a_wr: assert property (p_wr) else $error("write without store");
    property p_busy; start_w ##1 !flash_page_o[8] |-> ##[0:1] concurrent_read_block_o; endproperty
    a_busy: assert property (p_busy) else $error("busy not set");
    property p_rd; start_w ##1 !flash_page_o[8] |-> !cpu_halt_o [*4]; endproperty
    a_rd: assert property (p_rd) else $error("core halted on shared op");
    property p_halt; start_w ##1 flash_page_o[8] |-> ##[0:1] cpu_halt_o ##1 cpu_halt_o [*8]; endproperty
    a_halt: assert property (p_halt) else $error("core not halted");
    property p_hold; cpu_halt_o && $past(cpu_halt_o) |-> $stable(flash_page_o); endproperty
    a_hold: assert property (p_hold) else $error("page moved during op");
    property p_lock; !$stable(lock_bits_o) && !$past(rst_i) |-> $past(store_instr_i) || $past(store_instr_i, 2);
    endproperty
    a_lock: assert property (p_lock) else $error("lock bits moved alone");
    property p_irq; irq_o |-> $past(global_irq_en_i); endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
endmodule

// *** tb/cpu_core_model.sv ***
// Far-side model: CPU core issuing program-memory instructions, plus row data.
`timescale 1ns/1ps
module cpu_core_model #(
    parameter [7:0] FUSE_VAL = 8'h5A
) (
    // Clock and flash address
    input wire clk_sys_i,
    input wire [15:0] sig_addr_i,
    // Instruction strobes and operands
    output reg store_instr_o = 1'b0,
    output reg load_instr_o = 1'b0,
    output reg [7:0] r0_o = 8'h00,
    output reg [7:0] r1_o = 8'h00,
    // Flash row data
    output wire [7:0] sig_byte_o,
    output wire [7:0] fuse_byte_o
);
    // The row byte follows its address so a wrong index shows up.
    assign sig_byte_o = sig_addr_i[7:0] ^ 8'hA5;
    assign fuse_byte_o = FUSE_VAL;
    task issue(input st, input [7:0] a, input [7:0] b);
        begin
            @(posedge clk_sys_i);
            store_instr_o <= st;
            load_instr_o <= !st;
            r0_o <= a;
            r1_o <= b;
            @(posedge clk_sys_i);
            store_instr_o <= 1'b0;
            load_instr_o <= 1'b0;
            // Stale operands are inverted so a late read cannot pass.
            r0_o <= ~a;
            r1_o <= ~b;
        end
    endtask
endmodule

// *** tb/test_flash_self_program_control.sv ***
// Self-checking testbench for the flash self-programming control block.
`timescale 1ns/1ps
`include "flash_self_program_defs.vh"
module test_flash_self_program_control;
    reg clk_sys_i = 1'b0;
    reg rst_i = 1'b1;
    reg psel_i = 1'b0;
    reg penable_i = 1'b0;
    reg pwrite_i = 1'b0;
    reg global_irq_en_i = 1'b0;
    reg [11:0] paddr_i = 12'h000;
    reg [31:0] pwdata_i = 32'h00000000;
    reg [31:0] rdv;
    reg erv;
    reg [7:0] ld_q = 8'h00;
    integer fail_count = 0;
    integer tests_run = 0;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, store_instr_i, load_instr_i, load_special_o;
    wire flash_erase_o, flash_write_o, cpu_halt_o, concurrent_read_block_o, irq_o;
    wire [7:0] r0_i, r1_i, load_data_o, sig_byte_i, fuse_byte_i, lock_bits_o;
    wire [15:0] sig_addr_o, flash_wdata_o;
    wire [8:0] flash_page_o;
    wire [5:0] flash_widx_o;
    always #2.5 clk_sys_i = ~clk_sys_i;
    flash_self_program_control DUT (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .store_instr_i, .load_instr_i, .r0_i, .r1_i, .global_irq_en_i,
        .load_special_o, .load_data_o, .sig_byte_i, .fuse_byte_i, .sig_addr_o, .flash_page_o, .flash_erase_o,
        .flash_write_o, .flash_wdata_o, .flash_widx_o, .cpu_halt_o, .concurrent_read_block_o, .irq_o, .lock_bits_o);
    cpu_core_model #(.FUSE_VAL(8'h6C)) cpu (.clk_sys_i(clk_sys_i), .sig_addr_i(sig_addr_o),
        .store_instr_o(store_instr_i), .load_instr_o(load_instr_i), .r0_o(r0_i), .r1_o(r1_i),
        .sig_byte_o(sig_byte_i), .fuse_byte_o(fuse_byte_i));
    always @(posedge clk_sys_i) if (load_special_o === 1'b1) ld_q <= load_data_o;
    task cmp(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("BAD %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_sys_i);
            psel_i <= 1'b1;
            penable_i <= 1'b0;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= {24'h000000, d};
            @(posedge clk_sys_i);
            penable_i <= 1'b1;
            @(posedge clk_sys_i);
            while (pready_o !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk_sys_i);
            end
            cmp("pready", 32'h00000001, {31'h00000000, pready_o});
            rdv = prdata_o;
            erv = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task ctl(input [7:0] d);
        apb(1'b1, `SPC_OFF_CTRL, d);
    endtask
    task ptr(input [15:0] z);
        begin
            apb(1'b1, `SPC_OFF_PTR_LO, z[7:0]);
            apb(1'b1, `SPC_OFF_PTR_HI, z[15:8]);
        end
    endtask
    task wt(input integer n);
        begin
            repeat (n) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
        end
    endtask
    task idle;
        integer k;
        begin
            k = 0;
            rdv = 32'h00000001;
            while (rdv[0] !== 1'b0 && k < 200) begin
                k = k + 1;
                apb(1'b0, `SPC_OFF_CTRL, 8'h00);
            end
            cmp("idle", 32'h00000000, {31'h00000000, rdv[0]});
            wt(1);
        end
    endtask
    task ld(input [15:0] z, input [7:0] c);
        begin
            ptr(z);
            ctl(c);
            cpu.issue(1'b0, 8'h00, 8'h00);
            wt(1);
        end
    endtask
    task t_regs;
        begin
            apb(1'b0, `SPC_OFF_MISC, 8'h00);
            cmp("lockrst", 32'h000000FF, rdv);
            apb(1'b0, 12'h010, 8'h00);
            cmp("slverr", 32'h00000001, erv);
            ctl(8'h07);
            apb(1'b0, `SPC_OFF_CTRL, 8'h00);
            cmp("badcmd", 32'h00000000, rdv);
            ctl(8'h01);
            wt(6);
            apb(1'b0, `SPC_OFF_CTRL, 8'h00);
            cmp("expiry", 32'h00000000, rdv);
            $display("test regs done");
        end
    endtask
    task t_rww;
        begin
            ptr(16'h0800);
            ctl(8'h03);
            cpu.issue(1'b1, 8'hFF, 8'hFF);
            ptr(16'h0803);
            apb(1'b0, `SPC_OFF_PTR_HI, 8'h00);
            cmp("ptrhi", 32'h00000008, rdv);
            cmp("page", 32'h00000010, flash_page_o);
            cmp("block", 32'h00000001, concurrent_read_block_o);
            apb(1'b0, `SPC_OFF_CTRL, 8'h00);
            cmp("busyctl", 32'h00000043, rdv);
            ctl(8'h11);
            idle;
            cmp("kept", 32'h00000040, rdv);
            ctl(8'h01);
            cpu.issue(1'b1, 8'h34, 8'h12);
            wt(1);
            cmp("widx", 32'h00000001, flash_widx_o);
            cmp("wdata", 32'h00001234, flash_wdata_o);
            cmp("unblk", 32'h00000000, concurrent_read_block_o);
            ctl(8'h05);
            cpu.issue(1'b1, 8'h00, 8'h00);
            wt(1);
            cmp("block", 32'h00000001, concurrent_read_block_o);
            idle;
            ctl(8'h11);
            cpu.issue(1'b1, 8'h00, 8'h00);
            wt(1);
            cmp("reen", 32'h00000000, concurrent_read_block_o);
            $display("test shared area done");
        end
    endtask
    task t_non_concurrent_area;
        begin
            ptr(16'h8000);
            ctl(8'h03);
            cpu.issue(1'b1, 8'h00, 8'h00);
            wt(1);
            cmp("halt", 32'h00000001, cpu_halt_o);
            cmp("page", 32'h00000100, flash_page_o);
            idle;
            cmp("run", 32'h00000000, cpu_halt_o);
            $display("test private area done");
        end
    endtask
    task t_lock;
        begin
            ctl(8'h09);
            cpu.issue(1'b1, 8'hC3, 8'h5A);
            wt(1);
            cmp("lock", 32'h000000C3, lock_bits_o);
            ld(16'h0001, 8'h09);
            cmp("lockrd", 32'h000000C3, ld_q);
            ld(16'h0000, 8'h09);
            cmp("fuserd", 32'h0000006C, ld_q);
            ld(16'h0007, 8'h21);
            cmp("sig", 32'h000000A2, ld_q);
            ctl(8'h21);
            cpu.issue(1'b1, 8'h00, 8'h00);
            wt(1);
            cmp("sigstore", 32'h000000C3, lock_bits_o);
            $display("test lock done");
        end
    endtask
    task t_irq;
        begin
            @(posedge clk_sys_i);
            global_irq_en_i <= 1'b1;
            ctl(8'h80);
            wt(1);
            cmp("irq", 32'h00000001, irq_o);
            ctl(8'h81);
            wt(1);
            cmp("irqen", 32'h00000000, irq_o);
            @(posedge clk_sys_i);
            global_irq_en_i <= 1'b0;
            wt(6);
            cmp("irqgate", 32'h00000000, irq_o);
            $display("test irq done");
        end
    endtask
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs;
        t_rww;
        t_non_concurrent_area;
        t_lock;
        t_irq;
        give_verdict;
    end
    initial begin
        #100000;
        fail_count = fail_count + 1;
        give_verdict;
    end
endmodule
bind flash_self_program_control flash_self_program_checker chk (.clk_sys_i, .rst_i, .store_instr_i, .load_instr_i,
    .global_irq_en_i, .load_special_o, .cpu_halt_o, .concurrent_read_block_o, .irq_o, .flash_page_o,
    .flash_erase_o, .flash_write_o, .lock_bits_o);
